/* File: ccp_pkg.sv */
`default_nettype none

package ccp_pkg;

    // ==========================================================
    // Register map of the pair of units.
    // ==========================================================
    localparam int ADDR_W = 4;
    localparam logic [3:0] REG_CTL0 = 4'h0;
    localparam logic [3:0] REG_LOW0 = 4'h1;
    localparam logic [3:0] REG_HIGH0 = 4'h2;
    localparam logic [3:0] REG_CTL1 = 4'h3;
    localparam logic [3:0] REG_LOW1 = 4'h4;
    localparam logic [3:0] REG_HIGH1 = 4'h5;
    localparam logic [3:0] REG_FLAGS = 4'h6;
    localparam logic [3:0] REG_PINSEL = 4'h7;

    // ==========================================================
    // Field layout and reset values.
    // ==========================================================
    localparam int CTL_W = 6;
    localparam int DUTY_LSB = 4;
    localparam logic [5:0] CTL_RESET = 6'h00;
    localparam logic [15:0] CC_RESET = 16'h0000;
    localparam logic [9:0] DUTY_RESET = 10'h000;
    localparam logic [3:0] PRESC_RESET = 4'h0;
    localparam logic [3:0] PRESC4_LAST = 4'h3;
    localparam logic [3:0] PRESC16_LAST = 4'hf;
    localparam logic [3:0] PRESC_STEP = 4'h1;

    // ==========================================================
    // Mode field codes.
    // ==========================================================
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
    localparam logic [3:0] MODE_CMP_SET = 4'h8;
    localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
    localparam logic [3:0] MODE_CMP_SOFT = 4'ha;
    localparam logic [3:0] MODE_CMP_SPECIAL = 4'hb;
    localparam logic [1:0] GROUP_CAPTURE = 2'h1;
    localparam logic [1:0] GROUP_PWM = 2'h3;

    // ==========================================================
    // Carriers.
    // ==========================================================
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } bus_req_t;

    typedef struct packed {
        logic [5:0] ctl;
        logic [15:0] cc;
        logic [9:0] duty;
        logic outlat;
        logic level_prev;
        logic match_prev;
        logic [3:0] presc;
        logic flag;
    } unit_t;

    typedef struct packed {
        unit_t [1:0] u;
        logic [2:0] sync_a;
        logic [2:0] sync_b;
        logic pinsel;
        logic [7:0] rdata;
        logic timer_clear;
        logic adc_start;
    } state_t;

    // ==========================================================
    // Mode decoding shared by both units.
    // ==========================================================
    function automatic logic is_capture(input logic [3:0] mode);
        return mode[3:2] == GROUP_CAPTURE;
    endfunction

    function automatic logic is_pwm(input logic [3:0] mode);
        return mode[3:2] == GROUP_PWM;
    endfunction

    function automatic logic is_compare(input logic [3:0] mode);
        return (mode == MODE_CMP_TOGGLE) || (mode == MODE_CMP_SET) ||
            (mode == MODE_CMP_CLEAR) || (mode == MODE_CMP_SOFT) ||
            (mode == MODE_CMP_SPECIAL);
    endfunction

    function automatic logic drives_pin(input logic [3:0] mode);
        return is_pwm(mode) || (mode == MODE_CMP_TOGGLE) ||
            (mode == MODE_CMP_SET) || (mode == MODE_CMP_CLEAR);
    endfunction

endpackage

`default_nettype wire

/* File: capture_compare_pwm_unit.sv */
// Design decisions made here: the address map and the address-and-strobe port.

`default_nettype none

module capture_compare_pwm_unit (
    input wire logic clk,
    input wire logic rst_n,
    input wire ccp_pkg::bus_req_t bus_req,
    output logic [7:0] rdata,
    input wire logic [15:0] timer16,
    output logic timer16_clear,
    input wire logic [9:0] timer8_ext,
    input wire logic timer8_period_start,
    input wire logic adc_enable,
    output logic adc_start,
    input wire logic [2:0] pad_in,
    output logic [2:0] pad_out,
    output logic [2:0] pad_oe,
    input wire logic [1:0] pin_dir_in,
    input wire logic [1:0] port_data
);

    // ==========================================================
    // Reset release.
    // ==========================================================
    logic [1:0] rst_sync_r;
    logic rst_int_n;

    // The reset is released through two flip-flops so that every
    // state bit leaves reset on the same edge.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_sync_r <= 2'h0;
        end
        else
        begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_int_n = rst_sync_r[1];

    // ==========================================================
    // State.
    // ==========================================================
    ccp_pkg::state_t state_r;
    ccp_pkg::state_t state_nxt;

    // Pin-facing signals derived from the current state.
    logic [1:0] pad_level;
    logic [1:0] drive_level;
    logic [1:0] seen_level;
    logic [1:0] drives;

    // ==========================================================
    // Pin routing.
    // ==========================================================
    // Each unit picks its synchronised pad level; the second unit
    // takes it from whichever alternative pad is selected.
    always_comb
    begin
        pad_level[0] = state_r.sync_b[0];
        pad_level[1] = state_r.pinsel ? state_r.sync_b[2] : state_r.sync_b[1];
        for (int i = 0; i < 2; i++)
        begin
            drives[i] = ccp_pkg::drives_pin(state_r.u[i].ctl[3:0]);
            // The unit owns the pin level only in the modes that act on it.
            drive_level[i] = drives[i] ? state_r.u[i].outlat : port_data[i];
            // An output pin is watched at the level it is driven to.
            seen_level[i] = pin_dir_in[i] ? pad_level[i] : drive_level[i];
        end
    end

    // Pads are driven only while the direction bit marks an output.
    always_comb
    begin
        pad_out[0] = drive_level[0];
        pad_oe[0] = !pin_dir_in[0];
        pad_out[1] = !state_r.pinsel && drive_level[1];
        pad_oe[1] = !state_r.pinsel && !pin_dir_in[1];
        pad_out[2] = state_r.pinsel && drive_level[1];
        pad_oe[2] = state_r.pinsel && !pin_dir_in[1];
    end

    // ==========================================================
    // Next-state logic.
    // ==========================================================
    // Both units are worked through in one loop; all registers but the reset flip-flops,
    // pad synchronisers and read port included, live in one state record.
    always_comb
    begin
        logic [3:0] mode;
        logic rise;
        logic fall;
        logic cap_hit;
        logic match;
        logic cmp_hit;
        logic [9:0] duty_now;
        logic [9:0] duty_eff;
        logic [3:0] widx;
        logic [7:0] rd;
        mode = 4'h0;
        rise = 1'b0;
        fall = 1'b0;
        cap_hit = 1'b0;
        match = 1'b0;
        cmp_hit = 1'b0;
        duty_now = 10'h000;
        duty_eff = 10'h000;
        widx = 4'h0;
        rd = 8'h00;
        state_nxt = state_r;
        state_nxt.timer_clear = 1'b0;
        state_nxt.adc_start = 1'b0;

        // Two-stage synchronisers for the three pads.
        state_nxt.sync_a = pad_in;
        state_nxt.sync_b = state_r.sync_a;

        // Software writes to the shared registers.
        if (bus_req.we && (bus_req.addr == ccp_pkg::REG_PINSEL))
        begin
            state_nxt.pinsel = bus_req.wdata[0];
        end

        for (int i = 0; i < 2; i++)
        begin
            // Control, low and high byte of unit i sit three apart.
            widx = 4'(3 * i);
            if (bus_req.we && (bus_req.addr == widx + ccp_pkg::REG_CTL0))
            begin
                // Only the six implemented bits are stored.
                state_nxt.u[i].ctl = bus_req.wdata[ccp_pkg::CTL_W-1:0];
            end
            if (bus_req.we && (bus_req.addr == widx + ccp_pkg::REG_LOW0))
            begin
                state_nxt.u[i].cc[7:0] = bus_req.wdata;
            end
            if (bus_req.we && (bus_req.addr == widx + ccp_pkg::REG_HIGH0))
            begin
                state_nxt.u[i].cc[15:8] = bus_req.wdata;
            end
            // A written one clears the event flag of that unit.
            if (bus_req.we && (bus_req.addr == ccp_pkg::REG_FLAGS) && bus_req.wdata[i])
            begin
                state_nxt.u[i].flag = 1'b0;
            end

            // The mode in force is the one already stored.
            mode = state_r.u[i].ctl[3:0];
            state_nxt.u[i].level_prev = seen_level[i];
            rise = seen_level[i] && !state_r.u[i].level_prev;
            fall = !seen_level[i] && state_r.u[i].level_prev;

            // Capture events and the rising-edge prescaler.
            cap_hit = 1'b0;
            if (ccp_pkg::is_capture(mode))
            begin
                if (rise)
                begin
                    state_nxt.u[i].presc = state_r.u[i].presc + ccp_pkg::PRESC_STEP;
                end
                unique case (mode)
                    ccp_pkg::MODE_CAP_FALL: cap_hit = fall;
                    ccp_pkg::MODE_CAP_RISE: cap_hit = rise;
                    ccp_pkg::MODE_CAP_RISE4:
                        cap_hit = rise && (state_r.u[i].presc[1:0] == ccp_pkg::PRESC4_LAST[1:0]);
                    ccp_pkg::MODE_CAP_RISE16:
                        cap_hit = rise && (state_r.u[i].presc == ccp_pkg::PRESC16_LAST);
                endcase
            end
            else
            begin
                // Off and non-capture modes hold the prescaler cleared.
                state_nxt.u[i].presc = ccp_pkg::PRESC_RESET;
            end
            if (cap_hit)
            begin
                // A fresh capture always overwrites, even over a write.
                state_nxt.u[i].cc = timer16;
            end

            // Compare: one event per arrival of the timer at the value.
            match = (timer16 == state_r.u[i].cc);
            state_nxt.u[i].match_prev = match;
            cmp_hit = ccp_pkg::is_compare(mode) && match && !state_r.u[i].match_prev;
            if (cmp_hit)
            begin
                unique case (mode)
                    ccp_pkg::MODE_CMP_TOGGLE:
                        state_nxt.u[i].outlat = !state_r.u[i].outlat;
                    ccp_pkg::MODE_CMP_SET:
                        state_nxt.u[i].outlat = 1'b1;
                    ccp_pkg::MODE_CMP_CLEAR:
                        state_nxt.u[i].outlat = 1'b0;
                    ccp_pkg::MODE_CMP_SOFT:
                        state_nxt.u[i].outlat = state_r.u[i].outlat;
                    ccp_pkg::MODE_CMP_SPECIAL:
                    begin
                        // Clearing the shared timer shifts the other unit's view.
                        state_nxt.timer_clear = 1'b1;
                        if (i == 1)
                        begin
                            state_nxt.adc_start = adc_enable;
                        end
                    end
                endcase
            end

            // Any capture or compare event raises the flag; the set wins
            // over a clear written in the same cycle.
            if (cap_hit || cmp_hit)
            begin
                state_nxt.u[i].flag = 1'b1;
            end

            // PWM: duty reloads at the common period start, so both
            // units rise together and update at the same rate.
            duty_now = {state_r.u[i].cc[7:0], state_r.u[i].ctl[ccp_pkg::DUTY_LSB +: 2]};
            // The duty taken at a period start already governs that first count,
            // so a zero duty never lets the output rise.
            duty_eff = timer8_period_start ? duty_now : state_r.u[i].duty;
            if (ccp_pkg::is_pwm(mode))
            begin
                if (timer8_period_start)
                begin
                    state_nxt.u[i].duty = duty_now;
                    state_nxt.u[i].outlat = 1'b1;
                end
                if (timer8_ext == duty_eff)
                begin
                    state_nxt.u[i].outlat = 1'b0;
                end
            end

            // The off code and the reserved codes leave the unit idle.
            if (mode == ccp_pkg::MODE_OFF)
            begin
                state_nxt.u[i].outlat = 1'b0;
                state_nxt.u[i].presc = ccp_pkg::PRESC_RESET;
                state_nxt.u[i].duty = ccp_pkg::DUTY_RESET;
                state_nxt.u[i].match_prev = 1'b0;
            end
            // Codes 0001 and 0011 match none of the decoders above.
        end

        // Read data stand only in the cycle after the strobe.
        if (bus_req.re)
        begin
            unique case (bus_req.addr)
                ccp_pkg::REG_CTL0: rd = {2'h0, state_r.u[0].ctl};
                ccp_pkg::REG_LOW0: rd = state_r.u[0].cc[7:0];
                ccp_pkg::REG_HIGH0: rd = state_r.u[0].cc[15:8];
                ccp_pkg::REG_CTL1: rd = {2'h0, state_r.u[1].ctl};
                ccp_pkg::REG_LOW1: rd = state_r.u[1].cc[7:0];
                ccp_pkg::REG_HIGH1: rd = state_r.u[1].cc[15:8];
                ccp_pkg::REG_FLAGS: rd = {6'h00, state_r.u[1].flag, state_r.u[0].flag};
                ccp_pkg::REG_PINSEL: rd = {7'h00, state_r.pinsel};
                default: rd = 8'h00;
            endcase
        end
        state_nxt.rdata = rd;
    end

    // ==========================================================
    // State register.
    // ==========================================================
    // Every state bit starts from zero, which is the documented
    // reset of the control register and of the flags.
    always_ff @(posedge clk or negedge rst_int_n)
    begin
        if (!rst_int_n)
        begin
            state_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================
    // Outputs.
    // ==========================================================
    assign rdata = state_r.rdata;
    assign timer16_clear = state_r.timer_clear;
    assign adc_start = state_r.adc_start;

endmodule

`default_nettype wire

/* File: ccp_properties.sv */
`default_nettype none
// ==========================================
// Port checker for the capture/compare/PWM pair.
// ==========================================
module ccp_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire ccp_pkg::bus_req_t bus_req,
    input wire logic [7:0] rdata,
    input wire logic [15:0] timer16,
    input wire logic timer16_clear,
    input wire logic [9:0] timer8_ext,
    input wire logic timer8_period_start,
    input wire logic adc_enable,
    input wire logic adc_start,
    input wire logic [2:0] pad_in,
    input wire logic [2:0] pad_out,
    input wire logic [2:0] pad_oe,
    input wire logic [1:0] pin_dir_in,
    input wire logic [1:0] port_data
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // A conversion start always rides on a timer clear from a special event.
    a_start_with_clear: assert property (adc_start |-> timer16_clear)
        else $error("conversion start without timer clear");
    a_start_enabled: assert property (adc_start |-> $past(adc_enable))
        else $error("conversion start while converter disabled");
    a_clear_single: assert property (timer16_clear |=> !timer16_clear)
        else $error("timer clear longer than one cycle");
    a_ctl0_top_zero: assert property ($past(bus_req.re) &&
        ($past(bus_req.addr) == ccp_pkg::REG_CTL0) |-> rdata[7:6] == 2'h0)
        else $error("control 0 top bits not zero");
    a_ctl1_top_zero: assert property ($past(bus_req.re) &&
        ($past(bus_req.addr) == ccp_pkg::REG_CTL1) |-> rdata[7:6] == 2'h0)
        else $error("control 1 top bits not zero");
    // The first pad, and one of the two alternative pads, are driven exactly when their direction bit says output.
    a_pad0_dir: assert property (pad_oe[0] == !pin_dir_in[0])
        else $error("first pad drive disagrees with direction");
    a_pad1_dir: assert property ((pad_oe[1] || pad_oe[2]) == !pin_dir_in[1])
        else $error("second unit pad drive disagrees with direction");
    a_alt_one_pad: assert property (!(pad_oe[1] && pad_oe[2]))
        else $error("both alternative pads driven");
endmodule

bind capture_compare_pwm_unit ccp_properties u_ccp_properties (.clk(clk), .rst_n(rst_n),
    .bus_req(bus_req), .rdata(rdata), .timer16(timer16), .timer16_clear(timer16_clear),
    .timer8_ext(timer8_ext), .timer8_period_start(timer8_period_start),
    .adc_enable(adc_enable), .adc_start(adc_start), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .pin_dir_in(pin_dir_in), .port_data(port_data));
`default_nettype wire

/* File: ccp_pad_model.sv */
`default_nettype none
// ==========================================
// Pad side: an external event source on each pad.
// ==========================================
module ccp_pad_model (
    input wire logic [2:0] ext_lvl,
    input wire logic [2:0] pad_out,
    input wire logic [2:0] pad_oe,
    output logic [2:0] pad_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // A driven pad shows the unit's own level; port writes reach the edge detector through drive_level, not the pad.
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
endmodule
`default_nettype wire

/* File: testbench.sv */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, timer16_clear, timer8_period_start, adc_enable, adc_start;
    ccp_pkg::bus_req_t bus_req;
    logic [7:0] rdata;
    logic [15:0] timer16;
    logic [9:0] timer8_ext;
    logic [2:0] pad_in, pad_out, pad_oe, ext_lvl;
    logic [1:0] pin_dir_in, port_data;
    int num_errors = 0;
    int total_checks = 0;
    capture_compare_pwm_unit u_capture_compare_pwm_unit (.clk(clk), .rst_n(rst_n),
        .bus_req(bus_req), .rdata(rdata), .timer16(timer16), .timer16_clear(timer16_clear),
        .timer8_ext(timer8_ext), .timer8_period_start(timer8_period_start),
        .adc_enable(adc_enable), .adc_start(adc_start), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe(pad_oe), .pin_dir_in(pin_dir_in), .port_data(port_data));
    ccp_pad_model u_ccp_pad_model (.ext_lvl(ext_lvl), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_in(pad_in));
    // ==========================================
    // Clock and watchdog.
    // ==========================================
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // The whole run needs well under this many nanoseconds, which is 20000 cycles.
    initial
    begin
        #2000000;
        num_errors++;
        end_sim();
    end
    // ==========================================
    // Shared tasks.
    // ==========================================
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus_req.we <= 1'b0;
    endtask
    // Read data is looked at in the one cycle where it stands.
    task automatic rchk(input logic [3:0] a, input logic [7:0] e, input string n);
        @(posedge clk);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus_req.re <= 1'b0;
        @(negedge clk);
        chk(n, {8'h00, e}, {8'h00, rdata});
    endtask
    task automatic pulse(input logic [15:0] v);
        @(posedge clk);
        timer16 <= v;
        ext_lvl[0] <= 1'b1;
        repeat (5) @(posedge clk);
        ext_lvl[0] <= 1'b0;
        repeat (5) @(posedge clk);
    endtask
    task automatic match(input logic [15:0] v);
        @(posedge clk);
        timer16 <= v;
        @(posedge clk);
        timer16 <= v + 16'h0001;
        @(negedge clk);
    endtask
    function automatic logic next_lat(input logic [3:0] m, input logic lat);
        if (m == 4'h8)
            return 1'b1;
        if (m == 4'h9)
            return 1'b0;
        return (m == 4'h2) ? !lat : lat;
    endfunction
    // ==========================================
    // Main sequence.
    // ==========================================
    initial
    begin
        logic [15:0] t;
        logic [3:0] m, base;
        logic lat;
        logic [9:0] d0, d1;
        int n, h0, h1;
        static logic [3:0] cm [6] = '{4'h8, 4'h9, 4'h2, 4'ha, 4'h1, 4'h3};
        rst_n = 1'b0;
        bus_req = '0;
        timer16 = 16'h0000;
        timer8_ext = 10'h000;
        timer8_period_start = 1'b0;
        adc_enable = 1'b1;
        pin_dir_in = 2'b11;
        port_data = 2'b00;
        ext_lvl = 3'b000;
        void'($urandom(32'hf6132b1f));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        wr(4'h9, 8'hff);
        for (int a = 0; a < 16; a++)
            rchk(4'(a), 8'h00, "reset or unmapped value");
        wr(ccp_pkg::REG_CTL0, 8'hff);
        rchk(ccp_pkg::REG_CTL0, 8'h3f, "control top bits");
        // Capture modes, each entered from off so the prescaler starts clean.
        for (int i = 0; i < 4; i++)
        begin
            m = ccp_pkg::MODE_CAP_FALL + 4'(i);
            n = (i == 2) ? 4 : (i == 3) ? 16 : 1;
            wr(ccp_pkg::REG_CTL0, 8'h00);
            wr(ccp_pkg::REG_CTL0, {4'h0, m});
            wr(ccp_pkg::REG_FLAGS, 8'h03);
            for (int r = 0; r < 2; r++)
            begin
                repeat (n - 1) pulse(16'h0000);
                if (r == 0)
                    rchk(ccp_pkg::REG_FLAGS, 8'h00, "flag before last edge");
                t = 16'($urandom);
                pulse(t);
            end
            rchk(ccp_pkg::REG_LOW0, t[7:0], "captured low");
            rchk(ccp_pkg::REG_HIGH0, t[15:8], "captured high");
            rchk(ccp_pkg::REG_FLAGS, 8'h01, "capture flag");
            wr(ccp_pkg::REG_FLAGS, 8'h01);
            rchk(ccp_pkg::REG_FLAGS, 8'h00, "flag cleared");
        end
        // A port write on an output pin is seen as a pin edge.
        @(posedge clk);
        pin_dir_in[0] <= 1'b0;
        // A single rising edge captures, whatever the prescaler holds.
        wr(ccp_pkg::REG_CTL0, {4'h0, ccp_pkg::MODE_CAP_RISE});
        wr(ccp_pkg::REG_FLAGS, 8'h03);
        t = 16'($urandom);
        @(posedge clk);
        timer16 <= t;
        port_data[0] <= 1'b1;
        repeat (6) @(posedge clk);
        rchk(ccp_pkg::REG_LOW0, t[7:0], "port write capture");
        // Compare modes on the first unit, reserved codes among them.
        wr(ccp_pkg::REG_CTL0, 8'h00);
        // The port latch is low, so a pin the unit does not own reads low.
        port_data[0] <= 1'b0;
        lat = 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            t = 16'($urandom);
            @(posedge clk);
            timer16 <= ~t;
            wr(ccp_pkg::REG_LOW0, t[7:0]);
            wr(ccp_pkg::REG_HIGH0, t[15:8]);
            wr(ccp_pkg::REG_CTL0, {4'h0, cm[i]});
            wr(ccp_pkg::REG_FLAGS, 8'h01);
            match(t);
            lat = next_lat(cm[i], lat);
            n = (cm[i] == 4'h2 || cm[i] == 4'h8 || cm[i] == 4'h9) ? 32'(lat) : 0;
            chk("compare pin", 16'(n), 16'(pad_out[0]));
            rchk(ccp_pkg::REG_FLAGS, {7'h00, cm[i] != 4'h1 && cm[i] != 4'h3}, "cmp flag");
        end
        // Clearing the control word drops a high latch before any new match.
        wr(ccp_pkg::REG_CTL0, 8'h00);
        wr(ccp_pkg::REG_CTL0, {4'h0, ccp_pkg::MODE_CMP_SET});
        @(negedge clk);
        chk("latch after clear", 16'h0000, 16'(pad_out[0]));
        // Special event on each unit, then on the second with the converter off.
        for (int u = 0; u < 3; u++)
        begin
            base = (u > 0) ? ccp_pkg::REG_CTL1 : ccp_pkg::REG_CTL0;
            t = 16'($urandom);
            @(posedge clk);
            timer16 <= ~t;
            adc_enable <= (u < 2);
            wr(ccp_pkg::REG_CTL0, 8'h00);
            wr(base + 4'h1, t[7:0]);
            wr(base + 4'h2, t[15:8]);
            wr(base, {4'h0, ccp_pkg::MODE_CMP_SPECIAL});
            match(t);
            chk("timer clear", 16'h0001, 16'(timer16_clear));
            chk("conversion start", 16'(u == 1), 16'(adc_start));
        end
        // Both units in PWM, second unit on either pad, duty counted in cycles.
        @(posedge clk);
        pin_dir_in <= 2'b00;
        for (int i = 0; i < 4; i++)
        begin
            m = 4'hc + 4'(i);
            d0 = (i == 0) ? 10'h3ff : 10'($urandom);
            d1 = (i == 1) ? 10'h000 : 10'($urandom);
            wr(ccp_pkg::REG_PINSEL, {7'h00, m[0]});
            wr(ccp_pkg::REG_LOW0, d0[9:2]);
            wr(ccp_pkg::REG_CTL0, {2'b00, d0[1:0], m});
            wr(ccp_pkg::REG_LOW1, d1[9:2]);
            wr(ccp_pkg::REG_CTL1, {2'b00, d1[1:0], m});
            h0 = 0;
            h1 = 0;
            for (int k = 0; k < 1025; k++)
            begin
                @(posedge clk);
                timer8_ext <= 10'(k);
                timer8_period_start <= (k == 0);
                @(negedge clk);
                h0 += (pad_out[0] === 1'b1) ? 1 : 0;
                h1 += (pad_out[1 + m[0]] === 1'b1) ? 1 : 0;
            end
            chk("pwm high cycles first", 16'(d0), 16'(h0));
            chk("pwm high cycles second", 16'(d1), 16'(h1));
        end
        end_sim();
    end
endmodule
`default_nettype wire
